// file: design/et2_timer.sv
// Enhanced timer two: counter, reload/capture, baud and toggle output, APB slave
`timescale 1ns/100ps
`default_nettype none
module et2_timer
  import et2_pkg::*;
#(
  parameter int PSC_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_pin_in,
  output logic count_pin_out,
  output logic count_pin_oe_n,
  input wire logic trigger_pin,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic [15:0] time_base,
  output logic irq
);

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[11:10] == 2'b00) && (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  logic [7:0] ctl_r, mod_r, st_r, mask_r, rcap_lo_r, rcap_hi_r, cnt_lo_r, cnt_hi_r;
  logic [PSC_W-1:0] psc_r, psc_cnt_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  wire setup_w = psel && !penable;
  wire wr_w = psel && penable && pready_r && pwrite && ce;
  wire hit_ctl = hit(paddr, IDX_CONTROL);
  wire hit_mod = hit(paddr, IDX_MODE);
  wire hit_rlo = hit(paddr, IDX_RCAP_LO);
  wire hit_rhi = hit(paddr, IDX_RCAP_HI);
  wire hit_clo = hit(paddr, IDX_CNT_LO);
  wire hit_chi = hit(paddr, IDX_CNT_HI);
  wire hit_st = hit(paddr, IDX_STATUS);
  wire hit_msk = hit(paddr, IDX_MASK);
  wire hit_psc = hit(paddr, IDX_PRESCALE);
  wire mapped_w = hit_ctl | hit_mod | hit_rlo | hit_rhi | hit_clo | hit_chi | hit_st | hit_msk | hit_psc;
  wire wr_ctl = wr_w && hit_ctl;
  wire wr_rlo = wr_w && hit_rlo;
  wire wr_rhi = wr_w && hit_rhi;
  wire wr_clo = wr_w && hit_clo;
  wire wr_chi = wr_w && hit_chi;
  wire wr_st = wr_w && hit_st;
  wire sw_cnt_w = wr_clo || wr_chi;
  wire sw_rcap_w = wr_rlo || wr_rhi;

  wire [7:0] rd_byte_w =
    hit_ctl ? ctl_r :
    hit_mod ? mod_r :
    hit_rlo ? rcap_lo_r :
    hit_rhi ? rcap_hi_r :
    hit_clo ? cnt_lo_r :
    hit_chi ? cnt_hi_r :
    hit_st ? st_r :
    hit_msk ? mask_r :
    hit_psc ? {{(8-PSC_W){1'b0}}, psc_r} : RST_BYTE;

  // Zero-wait slave: data latched in setup, pready high for the one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      pready_r <= setup_w;
      pslverr_r <= setup_w && !mapped_w;
      if (setup_w) begin
        prdata_r <= {24'h00_0000, rd_byte_w};
      end
    end
  end

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic cnt_meta_r, cnt_sync_r, cnt_prev_r;
  logic trg_meta_r, trg_sync_r, trg_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_meta_r <= 1'b0;
      cnt_sync_r <= 1'b0;
      cnt_prev_r <= 1'b0;
      trg_meta_r <= 1'b0;
      trg_sync_r <= 1'b0;
      trg_prev_r <= 1'b0;
    end else if (ce) begin
      cnt_meta_r <= count_pin_in;
      cnt_sync_r <= cnt_meta_r;
      cnt_prev_r <= cnt_sync_r;
      trg_meta_r <= trigger_pin;
      trg_sync_r <= trg_meta_r;
      trg_prev_r <= trg_sync_r;
    end
  end

  // Relies on each pin level lasting a full clock
  wire cnt_fall_w = cnt_prev_r && !cnt_sync_r;
  wire trg_fall_w = trg_prev_r && !trg_sync_r;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire run_w = ctl_r[CTL_RUN];
  wire baud_sel_w = ctl_r[CTL_RCLK] || ctl_r[CTL_TRANSMIT_CLOCK_SELECT];
  wire [1:0] cm_w = mod_r[MOD_CM_HI:MOD_CM_LO];
  et2_mode_t mode_w;
  assign mode_w = !run_w ? M_OFF :
                  mod_r[MOD_TOE] ? M_FREQ :
                  baud_sel_w ? M_BAUD :
                  ctl_r[CTL_CPRL] ? M_CAPTURE :
                  mod_r[MOD_COUNT_DIRECTION_ENABLE] ? M_UPDOWN : M_RELOAD;
  // Enhanced count modes apply only to the reload, up-down and frequency modes, not to baud
  wire enh_w = (cm_w != CM_STD) && (mode_w inside {M_RELOAD, M_UPDOWN, M_FREQ});

  // Prescaler restarts while stopped or on a new divider, else a smaller divider waits for a wrap
  wire psc_tick_w = (psc_cnt_r == psc_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_cnt_r <= '0;
    end else if (ce) begin
      psc_cnt_r <= (!run_w || psc_tick_w || (wr_w && hit_psc)) ? '0 : psc_cnt_r + 1'b1;
    end
  end

  wire tick_w = run_w && (ctl_r[CTL_CSEL] ? cnt_fall_w : psc_tick_w);
  wire ext_evt_w = trg_fall_w && ctl_r[CTL_EXEN] && (mode_w inside {M_RELOAD, M_CAPTURE, M_BAUD, M_FREQ});
  wire ext_reload_w = ext_evt_w && !enh_w && (mode_w inside {M_RELOAD, M_FREQ});
  wire ext_capture_w = ext_evt_w && (mode_w == M_CAPTURE);

  // ****************************************************************
  // Counter next state
  // ****************************************************************
  wire [15:0] cnt_w = {cnt_hi_r, cnt_lo_r};
  wire [15:0] rcap_w = {rcap_hi_r, rcap_lo_r};
  logic [15:0] top_r, cnt_nxt, top_nxt;
  logic down_r, down_nxt, ovf_w;

  always_comb begin
    cnt_nxt = cnt_w + CNT_ONE;
    down_nxt = down_r;
    top_nxt = top_r;
    ovf_w = 1'b0;
    if (enh_w && cm_w == CM_CLEAR) begin
      if (cnt_w == rcap_w) begin
        cnt_nxt = CNT_MIN;
        ovf_w = 1'b1;
      end
    end else if (enh_w) begin
      if (!down_r && cnt_w >= top_r) begin
        down_nxt = 1'b1;
        cnt_nxt = (cnt_w == CNT_MIN) ? CNT_MIN : cnt_w - CNT_ONE;
        if (cm_w == CM_DUAL2) begin
          top_nxt = rcap_w;
        end
      end else if (down_r && cnt_w == CNT_MIN) begin
        down_nxt = 1'b0;
        ovf_w = 1'b1;
        top_nxt = rcap_w;
      end else if (down_r) begin
        cnt_nxt = cnt_w - CNT_ONE;
      end
    end else begin
      unique case (mode_w)
        M_UPDOWN: begin
          if (trg_sync_r && cnt_w == CNT_MAX) begin
            cnt_nxt = rcap_w;
            ovf_w = 1'b1;
          end else if (!trg_sync_r && cnt_w == rcap_w) begin
            cnt_nxt = CNT_MAX;
            ovf_w = 1'b1;
          end else if (!trg_sync_r) begin
            cnt_nxt = cnt_w - CNT_ONE;
          end
        end
        M_CAPTURE: begin
          ovf_w = (cnt_w == CNT_MAX);
        end
        M_RELOAD, M_BAUD, M_FREQ: begin
          if (cnt_w == CNT_MAX) begin
            cnt_nxt = rcap_w;
            ovf_w = 1'b1;
          end
        end
        M_OFF: begin
          cnt_nxt = cnt_w;
        end
      endcase
    end
  end

  wire ovf_evt_w = tick_w && ovf_w;
  wire ovf_set_w = ovf_evt_w && (mode_w != M_BAUD);

  // Software write wins over trigger, trigger over the count tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_r <= RST_BYTE;
      cnt_hi_r <= RST_BYTE;
      down_r <= 1'b0;
      top_r <= CNT_MIN;
    end else if (ce) begin
      if (sw_cnt_w) begin
        if (wr_clo) begin
          cnt_lo_r <= pwdata[7:0];
        end
        if (wr_chi) begin
          cnt_hi_r <= pwdata[7:0];
        end
      end else if (ext_reload_w) begin
        {cnt_hi_r, cnt_lo_r} <= rcap_w;
      end else if (tick_w) begin
        {cnt_hi_r, cnt_lo_r} <= cnt_nxt;
        down_r <= down_nxt;
        top_r <= top_nxt;
      end
      if (!enh_w) begin
        down_r <= 1'b0;
        top_r <= rcap_w;
      end
    end
  end

  // Reload/capture pair; software write beats a capture in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcap_lo_r <= RST_BYTE;
      rcap_hi_r <= RST_BYTE;
    end else if (ce) begin
      if (sw_rcap_w) begin
        if (wr_rlo) begin
          rcap_lo_r <= pwdata[7:0];
        end
        if (wr_rhi) begin
          rcap_hi_r <= pwdata[7:0];
        end
      end else if (ext_capture_w) begin
        {rcap_hi_r, rcap_lo_r} <= cnt_w;
      end
    end
  end

  // ****************************************************************
  // Control, flags and interrupt
  // ****************************************************************
  logic [7:0] ctl_nxt, st_nxt;
  always_comb begin
    ctl_nxt = wr_ctl ? pwdata[7:0] : ctl_r;
    ctl_nxt[CTL_OVF] = ctl_nxt[CTL_OVF] | ovf_set_w;
    ctl_nxt[CTL_EXT] = ctl_nxt[CTL_EXT] | ext_evt_w;
    st_nxt = st_r & ~(wr_st ? pwdata[7:0] : 8'h00);
    st_nxt[ST_OVF] = st_nxt[ST_OVF] | ovf_set_w;
    st_nxt[ST_EXT] = st_nxt[ST_EXT] | ext_evt_w;
  end

  logic toggle_r, oe_n_r, rx_tick_r, tx_tick_r, irq_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= RST_BYTE;
      mod_r <= RST_BYTE;
      st_r <= RST_BYTE;
      mask_r <= RST_BYTE;
      psc_r <= '0;
      toggle_r <= 1'b0;
      oe_n_r <= 1'b1;
      rx_tick_r <= 1'b0;
      tx_tick_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      ctl_r <= ctl_nxt;
      st_r <= st_nxt;
      if (wr_w && hit_mod) begin
        mod_r <= {4'h0, pwdata[3:0]};
      end
      if (wr_w && hit_msk) begin
        mask_r <= {6'h00, pwdata[1:0]};
      end
      if (wr_w && hit_psc) begin
        psc_r <= pwdata[PSC_W-1:0];
      end
      if (ovf_evt_w && mode_w == M_FREQ) begin
        toggle_r <= !toggle_r;
      end
      oe_n_r <= (mode_w != M_FREQ);
      rx_tick_r <= ovf_evt_w && (mode_w == M_BAUD) && ctl_r[CTL_RCLK];
      tx_tick_r <= ovf_evt_w && (mode_w == M_BAUD) && ctl_r[CTL_TRANSMIT_CLOCK_SELECT];
      irq_r <= |(st_nxt & mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign count_pin_out = toggle_r;
  assign count_pin_oe_n = oe_n_r;
  assign rx_baud_tick = rx_tick_r;
  assign tx_baud_tick = tx_tick_r;
  assign time_base = {cnt_hi_r, cnt_lo_r};
  assign irq = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire quiet_w = ce && !sw_cnt_w && !ext_reload_w;
  wire std_reload_w = (mode_w == M_RELOAD) && (cm_w == CM_STD);

  property p_timer_step;
    quiet_w && std_reload_w && !ctl_r[CTL_CSEL] && psc_r == '0 && cnt_w != CNT_MAX
      |=> time_base == $past(cnt_w) + CNT_ONE;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("Timer did not advance each clock");

  property p_psc_hold;
    quiet_w && run_w && !ctl_r[CTL_CSEL] && psc_cnt_r != psc_r |=> $stable(time_base);
  endproperty
  a_psc_hold: assert property (p_psc_hold) else $error("Count moved between prescaler ticks");

  property p_edge_count;
    quiet_w && std_reload_w && ctl_r[CTL_CSEL] && cnt_prev_r && !cnt_sync_r && cnt_w != CNT_MAX
      |=> time_base == $past(cnt_w) + CNT_ONE;
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("Falling edge not counted next cycle");

  property p_no_edge;
    quiet_w && run_w && ctl_r[CTL_CSEL] && !(cnt_prev_r && !cnt_sync_r) |=> $stable(time_base);
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("Counter moved without falling edge");

  property p_off_hold;
    quiet_w && !run_w |=> $stable(time_base);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("Stopped timer changed count");

  property p_capture;
    ce && ext_capture_w && !sw_rcap_w |=> {rcap_hi_r, rcap_lo_r} == $past(cnt_w);
  endproperty
  a_capture: assert property (p_capture) else $error("Capture did not latch count");

  property p_toggle;
    ce && ovf_evt_w && mode_w == M_FREQ |=> count_pin_out != $past(count_pin_out) && !count_pin_oe_n;
  endproperty
  a_toggle: assert property (p_toggle) else $error("Output pin not toggled on overflow");

  property p_baud;
    ce && ovf_evt_w && mode_w == M_BAUD && ctl_r[CTL_TRANSMIT_CLOCK_SELECT] |=> tx_baud_tick ##1 (!ce || !tx_baud_tick);
  endproperty
  a_baud: assert property (p_baud) else $error("Transmit baud tick missing or long");

  property p_ovf_flag;
    ce && ovf_set_w |=> ctl_r[CTL_OVF] && st_r[ST_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow flag not set");

  property p_ext_flag;
    ce && ext_evt_w |=> ctl_r[CTL_EXT] ##1 (!ce || wr_ctl || $past(wr_ctl) || ctl_r[CTL_EXT]);
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("External flag not held");

  property p_clear_match;
    quiet_w && tick_w && enh_w && cm_w == CM_CLEAR && cnt_w == rcap_w |=> time_base == CNT_MIN;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("Count not cleared on match");

  property p_down_reload;
    quiet_w && tick_w && !enh_w && mode_w == M_UPDOWN && !trg_sync_r && cnt_w == rcap_w
      |=> time_base == CNT_MAX;
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("Down count did not reload max");

  c_capture: cover property (ce && ext_capture_w);
  c_freq: cover property (ce && ovf_evt_w && mode_w == M_FREQ);
  c_baud: cover property (ce && rx_baud_tick);
  c_dual_turn: cover property (ce && tick_w && enh_w && down_r && cnt_w == CNT_MIN);

endmodule
`default_nettype wire

// file: design/et2_pkg.sv
// Constants, register map and mode types of the enhanced timer two
// ****************************************************************
// ****************************************************************
package et2_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'hc8;
  localparam logic [7:0] IDX_MODE = 8'hc9;
  localparam logic [7:0] IDX_RCAP_LO = 8'hca;
  localparam logic [7:0] IDX_RCAP_HI = 8'hcb;
  localparam logic [7:0] IDX_CNT_LO = 8'hcc;
  localparam logic [7:0] IDX_CNT_HI = 8'hcd;
  localparam logic [7:0] IDX_STATUS = 8'hd0;
  localparam logic [7:0] IDX_MASK = 8'hd1;
  localparam logic [7:0] IDX_PRESCALE = 8'hd2;
  // Control register bits
  localparam int CTL_OVF = 7;
  localparam int CTL_EXT = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_TRANSMIT_CLOCK_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CSEL = 1;
  localparam int CTL_CPRL = 0;
  // Mode register bits
  localparam int MOD_CM_HI = 3;
  localparam int MOD_CM_LO = 2;
  localparam int MOD_TOE = 1;
  localparam int MOD_COUNT_DIRECTION_ENABLE = 0;
  // Interrupt status bits
  localparam int ST_OVF = 0;
  localparam int ST_EXT = 1;
  // Values after reset, count limits and step, count-mode codes and mode types
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] CM_STD = 2'b00;
  localparam logic [1:0] CM_CLEAR = 2'b01;
  localparam logic [1:0] CM_DUAL1 = 2'b10;
  localparam logic [1:0] CM_DUAL2 = 2'b11;
  typedef enum logic [5:0] {
    M_OFF = 6'b000001,
    M_RELOAD = 6'b000010,
    M_UPDOWN = 6'b000100,
    M_CAPTURE = 6'b001000,
    M_BAUD = 6'b010000,
    M_FREQ = 6'b100000
  } et2_mode_t;
endpackage

// file: test/et2_pins.sv
// Model of the external count and trigger pins
`timescale 1ns/100ps
`default_nettype none
module et2_pins (
  input wire logic pclk,
  output logic cnt_drv,
  output logic trig_drv
);
  // **********
  // Pin drivers
  // **********
  // Pins idle high, as with a pull-up
  initial begin
    cnt_drv = 1'b1;
    trig_drv = 1'b1;
  end
  // Each level stands two clocks, so a one-clock sampler never misses it
  task automatic pulse(input bit trig, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (trig) trig_drv <= 1'b0; else cnt_drv <= 1'b0;
      repeat (2) @(posedge pclk);
      if (trig) trig_drv <= 1'b1; else cnt_drv <= 1'b1;
      @(posedge pclk);
    end
  endtask
  task automatic level(input logic v);
    @(posedge pclk);
    trig_drv <= v;
  endtask
endmodule
`default_nettype wire

// file: test/et2_timer_tb.sv
// Self-checking testbench of the enhanced timer two
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module et2_timer_tb
  import et2_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rx, tx;
  logic count_pin_out, count_pin_oe_n, last_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] time_base;
  logic er, ce;
  wire logic cnt_drv, trig_drv, count_pin_in;
  int mismatches, tests_run, cyc, nrx, ntx, ntog;
  // Design drives the pin only while its enable is low
  assign count_pin_in = count_pin_oe_n ? cnt_drv : count_pin_out;
  et2_timer dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin_in(count_pin_in), .count_pin_out(count_pin_out),
    .count_pin_oe_n(count_pin_oe_n), .trigger_pin(trig_drv), .rx_baud_tick(rx),
    .tx_baud_tick(tx), .time_base(time_base), .irq(irq));
  et2_pins pins_u (.pclk(pclk), .cnt_drv(cnt_drv), .trig_drv(trig_drv));
  // **********
  // Clock, monitors, timeout
  // **********
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Sampled on the falling edge so counts never race the main sequence
  always @(negedge pclk) begin
    if (rx === 1'b1) nrx++;
    if (tx === 1'b1) ntx++;
    if (count_pin_out !== last_out) ntog++;
    last_out = count_pin_out;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // **********
  // APB access
  // **********
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never rewrites psel in the same step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h00_0000, e})
  endtask
  task automatic set16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 8'h01, v[15:8]);
  endtask
  // **********
  // Main sequence
  // **********
  initial begin
    logic [7:0] regs [9];
    logic [7:0] ps [3];
    logic [7:0] dm [2];
    int s, t, bad;
    regs = '{IDX_CONTROL, IDX_MODE, IDX_RCAP_LO, IDX_RCAP_HI, IDX_CNT_LO, IDX_CNT_HI,
      IDX_STATUS, IDX_MASK, IDX_PRESCALE};
    ps = '{8'h00, 8'h03, 8'h0f};
    dm = '{8'h08, 8'h0c};
    ce = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rc(regs[i], 8'h00);
    apb(1'b0, 8'hc7, 8'h00);
    `CHK(er, 1'b1)
    // Prescaler: ticks seen in 16 clocks is 16 divided by v+1
    wr(IDX_CONTROL, 8'h04);
    foreach (ps[i]) begin
      wr(IDX_PRESCALE, ps[i]);
      repeat (4) @(posedge pclk);
      t = time_base;
      repeat (16) @(posedge pclk);
      `CHK(16'(time_base - t), 16'(16 / (ps[i] + 1)))
    end
    wr(IDX_PRESCALE, 8'h00);
    // Clock enable low freezes the running count
    ce <= 1'b0;
    @(posedge pclk);
    t = time_base;
    repeat (8) @(posedge pclk);
    `CHK(time_base, 16'(t))
    ce <= 1'b1;
    wr(IDX_CONTROL, 8'h00);
    // Standard reload from all-ones, overflow flag and interrupt
    set16(IDX_RCAP_LO, 16'h1234);
    set16(IDX_CNT_LO, 16'hfffe);
    wr(IDX_MASK, 8'h03);
    wr(IDX_CONTROL, 8'h04);
    repeat (6) @(posedge pclk);
    wr(IDX_CONTROL, 8'h00);
    `CHK((time_base >= 16'h1234) && (time_base < 16'h1240), 1'b1)
    `CHK(irq, 1'b1)
    wr(IDX_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(IDX_STATUS, 8'h01);
    wr(IDX_MASK, 8'h03);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    // Event counting on count pin falls
    set16(IDX_CNT_LO, 16'h0000);
    wr(IDX_CONTROL, 8'h06);
    pins_u.pulse(1'b0, 5);
    repeat (4) @(posedge pclk);
    `CHK(time_base, 16'h0005)
    // Capture on trigger fall, counter held still
    set16(IDX_CNT_LO, 16'h5a5a);
    wr(IDX_CONTROL, 8'h0f);
    pins_u.pulse(1'b1, 1);
    repeat (4) @(posedge pclk);
    rc(IDX_RCAP_LO, 8'h5a);
    rc(IDX_RCAP_HI, 8'h5a);
    rc(IDX_CONTROL, 8'h4f);
    `CHK(irq, 1'b1)
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_STATUS, 8'h03);
    // Frequency generator: reload FFFC gives a toggle every 4 clocks
    set16(IDX_RCAP_LO, 16'hfffc);
    set16(IDX_CNT_LO, 16'hfffc);
    wr(IDX_MODE, 8'h02);
    wr(IDX_CONTROL, 8'h04);
    repeat (4) @(posedge pclk);
    `CHK(count_pin_oe_n, 1'b0)
    s = ntog;
    repeat (40) @(posedge pclk);
    `CHK(ntog - s, 10)
    rc(IDX_CONTROL, 8'h84);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_MODE, 8'h00);
    // Baud generator: period 2, no overflow flag
    set16(IDX_RCAP_LO, 16'hfffe);
    set16(IDX_CNT_LO, 16'hfffe);
    wr(IDX_CONTROL, 8'h24);
    repeat (4) @(posedge pclk);
    s = nrx;
    t = ntx;
    repeat (20) @(posedge pclk);
    `CHK(nrx - s, 10)
    `CHK(ntx - t, 0)
    rc(IDX_CONTROL, 8'h24);
    // Transmit clock select alone moves the ticks to the transmit side
    wr(IDX_CONTROL, 8'h14);
    repeat (4) @(posedge pclk);
    s = nrx;
    t = ntx;
    repeat (20) @(posedge pclk);
    `CHK(ntx - t, 10)
    `CHK(nrx - s, 0)
    wr(IDX_CONTROL, 8'h00);
    // Up-down with the trigger pin low counts down
    pins_u.level(1'b0);
    set16(IDX_RCAP_LO, 16'h000c);
    set16(IDX_CNT_LO, 16'h0010);
    wr(IDX_MODE, 8'h01);
    wr(IDX_CONTROL, 8'h04);
    repeat (6) @(posedge pclk);
    wr(IDX_CONTROL, 8'h00);
    // Down from 0010 to the reload pair, then on from all-ones
    `CHK((time_base >= 16'hfff8) && (time_base < 16'hffff), 1'b1)
    pins_u.level(1'b1);
    // Clear on match: count never passes the reload pair
    set16(IDX_RCAP_LO, 16'h0003);
    set16(IDX_CNT_LO, 16'h0000);
    wr(IDX_MODE, 8'h04);
    wr(IDX_CONTROL, 8'h04);
    bad = 0;
    repeat (20) begin
      @(posedge pclk);
      if (time_base > 16'h0003) bad = 1;
    end
    `CHK(bad, 0)
    rc(IDX_CONTROL, 8'h84);
    wr(IDX_CONTROL, 8'h00);
    // Dual slope, single and double update: turns at the top, never above it
    foreach (dm[i]) begin
      set16(IDX_RCAP_LO, 16'h0004);
      set16(IDX_CNT_LO, 16'h0000);
      wr(IDX_MODE, dm[i]);
      wr(IDX_CONTROL, 8'h04);
      bad = 0;
      s = 0;
      repeat (20) begin
        @(posedge pclk);
        if (time_base > 16'h0004) bad = 1;
        if (time_base == 16'h0004) s++;
      end
      `CHK(bad, 0)
      `CHK(s > 1, 1'b1)
      rc(IDX_CONTROL, 8'h84); // dual slope
      wr(IDX_CONTROL, 8'h00);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
